// ---- inc/epi_pkg.sv ----
// constants and types shared by the external pin interrupt block
package epi_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [5:0] EPI_OFS_ASYNC_SENSE = 6'h00;
  localparam logic [5:0] EPI_OFS_SYNC_SENSE = 6'h04;
  localparam logic [5:0] EPI_OFS_MASK = 6'h08;
  localparam logic [5:0] EPI_OFS_FLAG = 6'h0C;
  localparam logic [5:0] EPI_OFS_CTRL = 6'h10;
  localparam logic [5:0] EPI_OFS_EVT_STATUS = 6'h14;
  localparam logic [5:0] EPI_OFS_EVT_CLEAR = 6'h18;
  localparam logic [5:0] EPI_OFS_EVT_ENABLE = 6'h1C;

  // reset values
  localparam logic [7:0] EPI_RST_ASYNC_SENSE = 8'h00;
  localparam logic [7:0] EPI_RST_SYNC_SENSE = 8'h00;
  localparam logic [7:0] EPI_RST_MASK = 8'h00;
  localparam logic [7:0] EPI_RST_FLAG = 8'h00;
  localparam logic [1:0] EPI_RST_CTRL = 2'h0;
  localparam logic [2:0] EPI_RST_EVT = 3'h0;

  // control register fields
  localparam int EPI_CTRL_IO_CLK_RUN = 0;
  localparam int EPI_CTRL_POWER_DOWN = 1;

  // event status / clear / enable layout
  localparam int EPI_EVT_FLAG_SET = 0;
  localparam int EPI_EVT_WAKE = 1;
  localparam int EPI_EVT_WAKE_NO_IRQ = 2;

  // split between asynchronous and clocked inputs
  localparam int EPI_N_ASYNC = 4;

  // sense select field encodings
  localparam logic [1:0] EPI_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPI_SENSE_CHANGE = 2'h1;
  localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

  // timing: clock and default wake start-up time
  localparam int EPI_CLK_MHZ = 125;
  localparam int EPI_STARTUP_US = 65;
  localparam int EPI_STARTUP_CYCLES = EPI_STARTUP_US * EPI_CLK_MHZ;

  typedef enum logic [1:0] {
    EPI_PD_IDLE,
    EPI_PD_SAMPLED_ONCE,
    EPI_PD_STARTUP
  } epi_pd_state_e;

endpackage

// ---- sim/epi_ext_pin_irq_bench.sv ----
// self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
module epi_ext_pin_irq_bench
  import epi_pkg::*;
();
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] e;} epi_row_s;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, gie, wdt_tick, sleep_active, irq_ack, wake, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] be;
  logic [2:0] ack_num;
  logic [7:0] pins, req;
  int failures = 0;
  int total_checks = 0;
  int wakes = 0;
  epi_row_s rows[9] = '{'{EPI_OFS_ASYNC_SENSE, 8'hE4, 8'hE4}, '{EPI_OFS_SYNC_SENSE, 8'h1B, 8'h1B},
    '{EPI_OFS_MASK, 8'hA5, 8'hA5}, '{EPI_OFS_CTRL, 8'h01, 8'h01}, '{EPI_OFS_EVT_ENABLE, 8'h07, 8'h07},
    '{EPI_OFS_EVT_CLEAR, 8'hFF, 8'h00}, '{EPI_OFS_EVT_STATUS, 8'hFF, 8'h00},
    '{EPI_OFS_FLAG, 8'hFF, 8'h00}, '{6'h20, 8'h5A, 8'h00}};

  epi_ext_pin_irq #(.STARTUP_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pins(pins),
    .global_irq_enable(gie), .wdt_tick(wdt_tick), .sleep_active(sleep_active), .irq_ack(irq_ack),
    .irq_ack_num(ack_num), .ext_irq_req(req), .wake(wake), .irq(irq));
  epi_pin_src i_src (.clk(clk), .ext_irq_pins(pins));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) wakes += (wake === 1'b1);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // holds the request until waitrequest is seen low, then releases
  // upper bytes carry copies of the data, which the block must ignore
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {d, d, d, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input string what, input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h000000, e}, q);
  endtask
  task automatic tick();
    wdt_tick <= 1'b1;
    @(posedge clk);
    wdt_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(8 * 5000);
    failures++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {gie, wdt_tick, sleep_active, irq_ack, ack_num} = '0;
    be = 4'hF;
    repeat (20) @(posedge clk);
    chk("outs_rst", 32'h400, {21'h0, avs_waitrequest, req, wake, irq});
    chk("rdata_rst", 32'h0, avs_readdata);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      rd("reset_val", rows[i].a, 8'h00);
      bus(1'b1, rows[i].a, rows[i].d);
      rd("readback", rows[i].a, rows[i].e);
    end
    be <= 4'hE;
    bus(1'b1, EPI_OFS_MASK, 8'h00);
    be <= 4'hF;
    rd("mask_no_be", EPI_OFS_MASK, 8'hA5);
    // input 0 held low in level mode
    gie <= 1'b1;
    sleep_active <= 1'b1;
    i_src.drive(8'hFE);
    repeat (10) @(posedge clk);
    chk("lvl_req", 32'h01, req);
    rd("lvl_flag", EPI_OFS_FLAG, 8'h00);
    chk("lvl_irq", 32'h0, irq);
    i_src.drive(8'hFF);
    repeat (6) @(posedge clk);
    chk("lvl_gone", 32'h00, req);
    sleep_active <= 1'b0;
    chk("lvl_wake", 32'h1, wakes);
    // fall on masked-in 2, change on masked-out 1
    i_src.pulse(8'h06);
    repeat (6) @(posedge clk);
    chk("edge_req", 32'h04, req);
    rd("edge_flag", EPI_OFS_FLAG, 8'h06);
    chk("edge_irq", 32'h1, irq);
    irq_ack <= 1'b1;
    ack_num <= 3'h2;
    @(posedge clk);
    irq_ack <= 1'b0;
    rd("ack_flag", EPI_OFS_FLAG, 8'h02);
    bus(1'b1, EPI_OFS_FLAG, 8'h02);
    rd("w1c_flag", EPI_OFS_FLAG, 8'h00);
    chk("ack_req", 32'h00, req);
    bus(1'b1, EPI_OFS_EVT_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, irq);
    // all modes at once, global enable off then on
    bus(1'b1, EPI_OFS_MASK, 8'hFF);
    gie <= 1'b0;
    i_src.pulse(8'hFF);
    repeat (6) @(posedge clk);
    chk("gie_off", 32'h00, req);
    rd("mode_flags", EPI_OFS_FLAG, 8'h7E);
    gie <= 1'b1;
    repeat (3) @(posedge clk);
    chk("gie_on", 32'h7E, req);
    // clocked inputs blind without the io clock
    gie <= 1'b0;
    bus(1'b1, EPI_OFS_FLAG, 8'hFF);
    bus(1'b1, EPI_OFS_CTRL, 8'h00);
    i_src.pulse(8'hFF);
    repeat (6) @(posedge clk);
    rd("no_io_clk", EPI_OFS_FLAG, 8'h0E);
    // input 3 from rise to fall in the safe order
    bus(1'b1, EPI_OFS_MASK, 8'hF7);
    bus(1'b1, EPI_OFS_ASYNC_SENSE, 8'hA4);
    bus(1'b1, EPI_OFS_FLAG, 8'hFF);
    bus(1'b1, EPI_OFS_MASK, 8'hFF);
    gie <= 1'b1;
    i_src.drive(8'hF7);
    repeat (6) @(posedge clk);
    chk("r12_fall", 32'h08, req);
    i_src.drive(8'hFF);
    bus(1'b1, EPI_OFS_FLAG, 8'hFF);
    // power-down wake, level lost before start-up ends
    bus(1'b1, EPI_OFS_EVT_CLEAR, 8'h07);
    bus(1'b1, EPI_OFS_CTRL, 8'h02);
    sleep_active <= 1'b1;
    gie <= 1'b1;
    i_src.drive(8'hFE);
    repeat (3) @(posedge clk);
    tick();
    tick();
    i_src.drive(8'hFF);
    for (int k = 0; k < 100 && wakes < 2; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("wakes", 32'h2, wakes);
    rd("wake_status", EPI_OFS_EVT_STATUS, 8'h06);
    // reset again with the block configured
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("outs_rst2", 32'h400, {21'h0, avs_waitrequest, req, wake, irq});
    rst <= 1'b0;
    @(posedge clk);
    rd("mask_rst2", EPI_OFS_MASK, 8'h00);
    rd("async_rst2", EPI_OFS_ASYNC_SENSE, 8'h00);
    close_out();
  end
endmodule

// ---- sim/epi_ext_pin_irq_chk.sv ----
// assertion checker for the external pin interrupt block
`timescale 1ns/100ps
module epi_ext_pin_irq_chk
  import epi_pkg::*;
#(
  parameter int STARTUP_CYCLES = EPI_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] ext_irq_pins,
  input wire logic global_irq_enable,
  input wire logic wdt_tick,
  input wire logic sleep_active,
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_num,
  input wire logic [7:0] ext_irq_req,
  input wire logic wake,
  input wire logic irq
);
  // config shadow rebuilt from completed writes, since the registers are not ports
  logic [7:0] mask_sh;
  logic [15:0] sense_sh;
  logic [1:0] ctrl_sh;
  logic wr_done;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_sh <= 8'h00;
      sense_sh <= 16'h0000;
      ctrl_sh <= 2'h0;
    end else if (wr_done) begin
      case (avs_address)
        EPI_OFS_MASK: mask_sh <= avs_writedata[7:0];
        EPI_OFS_ASYNC_SENSE: sense_sh[7:0] <= avs_writedata[7:0];
        EPI_OFS_SYNC_SENSE: sense_sh[15:8] <= avs_writedata[7:0];
        EPI_OFS_CTRL: ctrl_sh <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  chk_mask_gate: assert property ((ext_irq_req & ~$past(mask_sh)) == 8'h00)
    else $error("request on a masked input");
  chk_gie_gate: assert property (|ext_irq_req |-> $past(global_irq_enable))
    else $error("request without global enable");
  chk_level_hold: assert property ((sense_sh[1:0] == EPI_SENSE_LOW && !ctrl_sh[1] && mask_sh[0]
    && global_irq_enable && !ext_irq_pins[0])[*3] |=> ext_irq_req[0]) else $error("low level gave no request");
  chk_fall_edge: assert property ($fell(ext_irq_pins[2]) && sense_sh[5:4] == EPI_SENSE_FALL
    ##0 (mask_sh[2] && global_irq_enable && !irq_ack)[*4] |=> ext_irq_req[2]) else $error("falling edge missed");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer");
  chk_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
endmodule

bind epi_ext_pin_irq epi_ext_pin_irq_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ext_irq_pins(ext_irq_pins), .global_irq_enable(global_irq_enable),
  .wdt_tick(wdt_tick), .sleep_active(sleep_active), .irq_ack(irq_ack), .irq_ack_num(irq_ack_num),
  .ext_irq_req(ext_irq_req), .wake(wake), .irq(irq)
);

// ---- sim/epi_pin_src.sv ----
// behavioural source driving the external interrupt pins
`timescale 1ns/100ps
module epi_pin_src (
  input wire logic clk,
  output logic [7:0] ext_irq_pins
);
  // idle high, as behind pull-ups
  initial ext_irq_pins = 8'hFF;
  task automatic drive(input logic [7:0] level);
    ext_irq_pins <= level;
  endtask
  // 8 cycles is 64 ns, above the minimum width
  task automatic pulse(input logic [7:0] which);
    ext_irq_pins <= ext_irq_pins & ~which;
    repeat (8) @(posedge clk);
    ext_irq_pins <= ext_irq_pins | which;
  endtask
endmodule

// ---- verilog/epi_ext_pin_irq.sv ----
// external pin interrupt controller with Avalon-MM register slave
//
// Behaviour
// - pin activity raises requests even when the pin is driven as an output.
// - low-level mode keeps the request asserted as long as the pin is low, except while power-down is set or waking.
// - low levels on all inputs and edges on 3..0 work with the I/O clock stopped.
// - edges on inputs 7..4 are detected only while the I/O clock runs.
// - power-down level wake samples twice on watchdog ticks, then waits start-up.
// - level gone at end of start-up still wakes but raises no interrupt.
// - inputs 3..0 request only with global enable and mask bit set.
// - async sense register holds 2-bit fields, input 3 at 7:6, reset zero.
// - async field codes: low level, any change, falling edge, rising edge.
// - inputs 7..4 request only with global enable and mask bit set.
// - inputs 7..4 sampled each clock, edges found by comparing samples.
// - sync field codes: low level, any change, falling edge, rising edge.
// - eight-bit read/write mask register, bit n for input n, reset zero.
// - triggering edge sets flag; with mask and global enable it requests.
// - flag cleared by handler acknowledge or by writing one to it.
// - flag held cleared while its input is in level mode.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps

module epi_ext_pin_irq
  import epi_pkg::*;
#(
  parameter int STARTUP_CYCLES = EPI_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] ext_irq_pins,
  input wire logic global_irq_enable,
  input wire logic wdt_tick,
  input wire logic sleep_active,
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_num,
  output logic [7:0] ext_irq_req,
  output logic wake,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic sense_hit(input logic [1:0] sel, input logic now, input logic prev);
    logic hit;
    hit = 1'b0;
    case (sel)
      EPI_SENSE_CHANGE: hit = now ^ prev;
      EPI_SENSE_FALL: hit = prev & ~now;
      EPI_SENSE_RISE: hit = now & ~prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] apply_be8(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] be);
    return be[0] ? wd[7:0] : old;
  endfunction

  // any masked input holding a low level
  function automatic logic any_wake_level(input logic [7:0] low, input logic [7:0] mask);
    return |(low & mask);
  endfunction

  // a completed write to one register with byte 0 enabled
  function automatic logic wr_hit(input logic wr, input logic [5:0] addr, input logic [3:0] be,
                                  input logic [5:0] ofs);
    return wr && (addr == ofs) && be[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] async_int_sense_control_reg;
  logic [7:0] sync_int_sense_control_reg;
  logic [7:0] ext_irq_mask_reg;
  logic [7:0] ext_irq_flag_reg;
  logic [1:0] ctrl_reg;
  logic [2:0] evt_status_reg;
  logic [2:0] evt_enable_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] pin_prev_reg;
  logic [7:0] req_reg;
  logic wake_reg;
  logic irq_reg;
  epi_pd_state_e pd_state_reg;
  logic [31:0] startup_cnt_reg;
  logic lvl_wake_seen_reg;

  logic [15:0] sense_all;
  logic [7:0] level_mode;
  logic [7:0] edge_evt;
  logic [7:0] flag_clr;
  logic [7:0] flag_next;
  logic [7:0] level_low;
  logic io_clk_run;
  logic power_down;
  logic pd_hold;
  logic pd_done;
  logic pd_no_irq;
  logic [2:0] evt_set;
  logic acc_ok;
  logic do_wr;
  logic lvl_wake;

  assign io_clk_run = ctrl_reg[EPI_CTRL_IO_CLK_RUN];
  assign power_down = ctrl_reg[EPI_CTRL_POWER_DOWN];
  assign sense_all = {sync_int_sense_control_reg, async_int_sense_control_reg};
  // access completes in the cycle after waitrequest drops
  assign acc_ok = ~waitrequest_reg;
  assign do_wr = avs_write & acc_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers; pins are read whatever their direction
  // presets match the pulled-up idle level, so reset release shows no false edge

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 8'hFF;
      pin_sync_reg <= 8'hFF;
      pin_prev_reg <= 8'hFF;
    end else begin
      pin_meta_reg <= ext_irq_pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense decode and edge events

  always_comb begin
    level_mode = 8'h00;
    edge_evt = 8'h00;
    level_low = 8'h00;
    for (int i = 0; i < 8; i++) begin
      level_mode[i] = (sense_all[2*i +: 2] == EPI_SENSE_LOW);
      level_low[i] = level_mode[i] & ~pin_sync_reg[i];
      if (i < EPI_N_ASYNC) begin
        edge_evt[i] = sense_hit(sense_all[2*i +: 2], pin_sync_reg[i], pin_prev_reg[i]);
      end else begin
        // clocked inputs see no edges while the I/O clock is halted
        edge_evt[i] = io_clk_run & sense_hit(sense_all[2*i +: 2], pin_sync_reg[i], pin_prev_reg[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags: set wins over clear, level mode forces clear

  always_comb begin
    flag_clr = 8'h00;
    if (wr_hit(do_wr, avs_address, avs_byteenable, EPI_OFS_FLAG)) begin
      flag_clr = avs_writedata[7:0];
    end
    if (irq_ack) begin
      flag_clr[irq_ack_num] = 1'b1;
    end
    flag_next = ((ext_irq_flag_reg & ~flag_clr) | edge_evt) & ~level_mode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_irq_flag_reg <= EPI_RST_FLAG;
    end else begin
      ext_irq_flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // level requests stay up while the pin is low, except while power-down is set or its wake sequence runs
        req_reg[i] <= global_irq_enable & ext_irq_mask_reg[i] &
                      (flag_next[i] | (level_low[i] & ~pd_hold));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down level wake sequencer

  assign pd_hold = power_down | (pd_state_reg != EPI_PD_IDLE);
  assign pd_done = (pd_state_reg == EPI_PD_STARTUP) && (startup_cnt_reg == 32'h0);
  // no interrupt when the level vanished before the start-up time ended
  assign pd_no_irq = pd_done & ~any_wake_level(level_low, ext_irq_mask_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_state_reg <= EPI_PD_IDLE;
      startup_cnt_reg <= 32'h0;
    end else begin
      case (pd_state_reg)
        EPI_PD_IDLE: begin
          // one low sample is not enough; noise must survive two watchdog ticks
          if (power_down && wdt_tick && any_wake_level(level_low, ext_irq_mask_reg)) begin
            pd_state_reg <= EPI_PD_SAMPLED_ONCE;
          end
        end
        EPI_PD_SAMPLED_ONCE: begin
          if (wdt_tick) begin
            if (any_wake_level(level_low, ext_irq_mask_reg)) begin
              pd_state_reg <= EPI_PD_STARTUP;
              // counts down so pd_done lands after exactly STARTUP_CYCLES cycles
              startup_cnt_reg <= 32'(STARTUP_CYCLES - 1);
            end else begin
              pd_state_reg <= EPI_PD_IDLE;
            end
          end
        end
        EPI_PD_STARTUP: begin
          if (startup_cnt_reg == 32'h0) begin
            pd_state_reg <= EPI_PD_IDLE;
          end else begin
            startup_cnt_reg <= startup_cnt_reg - 32'h1;
          end
        end
        default: pd_state_reg <= EPI_PD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake output and event interrupt

  // level wake from the other clock-stopped sleep modes, once per low episode
  assign lvl_wake = sleep_active & ~power_down & any_wake_level(level_low, ext_irq_mask_reg) &
                    ~lvl_wake_seen_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_wake_seen_reg <= 1'b0;
    end else begin
      lvl_wake_seen_reg <= sleep_active & ~power_down & any_wake_level(level_low, ext_irq_mask_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      // clockless-class events on 3..0 wake from any sleep mode
      wake_reg <= pd_done | lvl_wake |
                  (sleep_active & |(edge_evt[EPI_N_ASYNC-1:0] & ext_irq_mask_reg[EPI_N_ASYNC-1:0]));
    end
  end

  assign evt_set = {pd_no_irq, pd_done, |(edge_evt & ~level_mode)};
  // an event landing in the cycle of its clear is kept

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status_reg <= EPI_RST_EVT;
    end else if (wr_hit(do_wr, avs_address, avs_byteenable, EPI_OFS_EVT_CLEAR)) begin
      evt_status_reg <= (evt_status_reg & ~avs_writedata[2:0]) | evt_set;
    end else begin
      evt_status_reg <= evt_status_reg | evt_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      // registered for a clean output, one cycle behind the status bits
      irq_reg <= |(evt_status_reg & evt_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      async_int_sense_control_reg <= EPI_RST_ASYNC_SENSE;
      sync_int_sense_control_reg <= EPI_RST_SYNC_SENSE;
      ext_irq_mask_reg <= EPI_RST_MASK;
      ctrl_reg <= EPI_RST_CTRL;
      evt_enable_reg <= EPI_RST_EVT;
    end else if (do_wr) begin
      case (avs_address)
        EPI_OFS_ASYNC_SENSE: async_int_sense_control_reg <= apply_be8(async_int_sense_control_reg,
                                                                      avs_writedata, avs_byteenable);
        EPI_OFS_SYNC_SENSE: sync_int_sense_control_reg <= apply_be8(sync_int_sense_control_reg,
                                                                    avs_writedata, avs_byteenable);
        EPI_OFS_MASK: ext_irq_mask_reg <= apply_be8(ext_irq_mask_reg, avs_writedata, avs_byteenable);
        EPI_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_reg <= avs_writedata[1:0];
          end
        end
        EPI_OFS_EVT_ENABLE: begin
          if (avs_byteenable[0]) begin
            evt_enable_reg <= avs_writedata[2:0];
          end
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake and read data
  // one wait state: taken with waitrequest high, answered in the next cycle

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
    end else if ((avs_read || avs_write) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_reg <= 32'h0;
    end else if (avs_read && waitrequest_reg) begin
      case (avs_address)
        EPI_OFS_ASYNC_SENSE: readdata_reg <= {24'h0, async_int_sense_control_reg};
        EPI_OFS_SYNC_SENSE: readdata_reg <= {24'h0, sync_int_sense_control_reg};
        EPI_OFS_MASK: readdata_reg <= {24'h0, ext_irq_mask_reg};
        EPI_OFS_FLAG: readdata_reg <= {24'h0, ext_irq_flag_reg};
        EPI_OFS_CTRL: readdata_reg <= {30'h0, ctrl_reg};
        EPI_OFS_EVT_STATUS: readdata_reg <= {29'h0, evt_status_reg};
        EPI_OFS_EVT_ENABLE: readdata_reg <= {29'h0, evt_enable_reg};
        default: readdata_reg <= 32'h0;
      endcase
    end else begin
      // data stands only in the answer cycle, so no stale value is taken later
      readdata_reg <= 32'h0;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign ext_irq_req = req_reg;
  assign wake = wake_reg;
  assign irq = irq_reg;

endmodule
